/* clkdist_top.sv */
/*
 clkdist_top: AXI4-Lite configuration registers, oscillator path selection,
 eight output channels, calibration and sync requests, lock detect prescale.
 assumes outputs_enable_pin and align_n_pin are asynchronous pins; pd_tick is on ref_clk.
*/
`timescale 1ns/1ps
module clkdist_top
	import clkdist_pkg::*;
#(
	parameter int CAL_LEN = CAL_CYCLES
)(
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	// axi4-lite write address
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// pins
	input  wire logic                    outputs_enable_pin,
	input  wire logic                    align_n_pin,
	// lock detect
	input  wire logic                    pd_tick,
	output logic                         ld_tick,
	// loop and swing settings, calibration and sync status
	output logic                         output_swing_raise,
	output logic [3:0]                   loop_filter_cap_code,
	output logic                         feedback_from_selector,
	output logic                         calibrating,
	output logic                         sync_pulse,
	// channel outputs
	output logic [NUM_CH-1:0]            ch_clk,
	output logic [NUM_CH-1:0]            ch_out_en,
	output logic [NUM_CH-1:0][11:0]      ch_delay_ps
);
	logic [NUM_CH-1:0][31:0] ch_word_reg;
	logic [31:0]  swing_reg;
	logic [31:0]  prescale_reg;
	logic [31:0]  loop_filter_reg;
	logic [31:0]  fixed_reg;
	logic [31:0]  global_reg;
	logic [31:0]  feedback_reg;
	logic [7:0]   aw_addr_reg;
	logic         aw_full_reg;
	logic [31:0]  w_data_reg;
	logic [3:0]   w_strb_reg;
	logic         w_full_reg;
	logic         do_write;
	logic         wr_hit;
	logic [31:0]  rd_word;
	logic         rd_hit;
	logic [2:0]   oe_sync_reg;
	logic [2:0]   al_sync_reg;
	logic         oe_level_reg;
	logic         al_level_reg;
	logic         align;
	logic [3:0]   osc_cnt_reg;
	logic         osc_div_tick;
	logic         path_tick;
	logic [31:0]  cal_cnt_reg;
	logic [1:0]   pre_cnt_reg;
	logic         gate;
	logic         fb_write;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_ch(input logic [7:0] a);
		return (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
	endfunction

	// write channel: address and data in either order
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_reg <= 1'b0;
		end
	end

	always_comb begin
		wr_hit = is_ch(aw_addr_reg);
		case (aw_addr_reg)
			SWING_OFS, PRESCALE_OFS, LOOP_FILTER_OFS, FIXED_OFS,
			GLOBAL_OFS, FEEDBACK_OFS, STATUS_OFS: wr_hit = 1'b1;
			default: ;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register file
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ch_word_reg[i] <= {16'h0000, DIV_RESET, 8'h00};
			end
		end else if (do_write && is_ch(aw_addr_reg)) begin
			ch_word_reg[aw_addr_reg[4:2]] <= merge(ch_word_reg[aw_addr_reg[4:2]],
				w_data_reg, w_strb_reg);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			swing_reg       <= 32'h00000000;
			prescale_reg    <= 32'h00000000;
			loop_filter_reg <= 32'h00000000;
			fixed_reg       <= 32'h00000000;
			global_reg      <= {4'h0, ALL_EN_RESET, 27'h0000000};
			feedback_reg    <= {2'h0, OSC_DIV_RESET, FB_COUNT_RESET, 8'h00};
		end else if (do_write) begin
			case (aw_addr_reg)
				SWING_OFS:       swing_reg <= merge(swing_reg, w_data_reg, w_strb_reg);
				PRESCALE_OFS:    prescale_reg <= merge(prescale_reg, w_data_reg, w_strb_reg);
				LOOP_FILTER_OFS: loop_filter_reg <= merge(loop_filter_reg, w_data_reg,
					w_strb_reg);
				FIXED_OFS:       fixed_reg <= merge(fixed_reg, w_data_reg, w_strb_reg);
				GLOBAL_OFS:      global_reg <= merge(global_reg, w_data_reg, w_strb_reg);
				FEEDBACK_OFS:    feedback_reg <= merge(feedback_reg, w_data_reg, w_strb_reg);
				default: ;
			endcase
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		if (is_ch(s_axi_araddr)) begin
			rd_word = ch_word_reg[s_axi_araddr[4:2]];
		end else begin
			case (s_axi_araddr)
				SWING_OFS:       rd_word = swing_reg;
				PRESCALE_OFS:    rd_word = prescale_reg;
				LOOP_FILTER_OFS: rd_word = loop_filter_reg;
				FIXED_OFS:       rd_word = fixed_reg;
				GLOBAL_OFS:      rd_word = global_reg;
				FEEDBACK_OFS:    rd_word = feedback_reg;
				STATUS_OFS:      rd_word = {29'h00000000, oe_level_reg, al_level_reg,
					calibrating};
				default:         rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// pin synchronisers, a change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			oe_sync_reg  <= 3'h0;
			al_sync_reg  <= 3'h7;
			oe_level_reg <= 1'b0;
			al_level_reg <= 1'b1;
		end else begin
			oe_sync_reg <= {oe_sync_reg[1:0], outputs_enable_pin};
			al_sync_reg <= {al_sync_reg[1:0], align_n_pin};
			if (oe_sync_reg[1] == oe_sync_reg[2]) begin
				oe_level_reg <= oe_sync_reg[2];
			end
			if (al_sync_reg[1] == al_sync_reg[2]) begin
				al_level_reg <= al_sync_reg[2];
			end
		end
	end

	assign align = !al_level_reg;
	assign gate  = global_reg[ALL_EN_BIT] & oe_level_reg;

	// oscillator divider and path select
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			osc_cnt_reg <= 4'h0;
		end else if (align || osc_div_tick) begin
			osc_cnt_reg <= 4'h0;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 4'h1;
		end
	end

	assign osc_div_tick = (osc_cnt_reg + 4'h1 >= feedback_reg[OSC_DIV_LSB +: 4]);
	assign path_tick = (ch_word_reg[NUM_CH-1][OSC_SEL_LSB +: 2] == OSC_DIRECT) ?
		1'b1 : osc_div_tick;

	// sync on feedback word write, calibration too outside zero-delay operation
	assign fb_write = do_write && (aw_addr_reg == FEEDBACK_OFS);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cal_cnt_reg <= 32'h00000000;
			calibrating <= 1'b0;
			sync_pulse  <= 1'b0;
		end else begin
			sync_pulse <= fb_write;
			if (fb_write && !global_reg[ZERO_DLY_BIT]) begin
				cal_cnt_reg <= 32'(CAL_LEN);
				calibrating <= 1'b1;
			end else if (cal_cnt_reg > 32'h00000001) begin
				cal_cnt_reg <= cal_cnt_reg - 32'h00000001;
			end else begin
				cal_cnt_reg <= 32'h00000000;
				calibrating <= 1'b0;
			end
		end
	end

	// lock detect prescale
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pre_cnt_reg <= 2'h0;
			ld_tick     <= 1'b0;
		end else begin
			if (pd_tick) begin
				pre_cnt_reg <= pre_cnt_reg + 2'h1;
			end
			ld_tick <= prescale_reg[PRESCALE_BIT] ?
				(pd_tick && pre_cnt_reg == PRESCALE_LAST) : pd_tick;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			output_swing_raise     <= 1'b0;
			loop_filter_cap_code   <= 4'h0;
			feedback_from_selector <= 1'b0;
		end else begin
			output_swing_raise     <= swing_reg[SWING_BIT];
			loop_filter_cap_code   <= loop_filter_reg[CAP_LSB +: 4];
			feedback_from_selector <= global_reg[ZERO_DLY_BIT];
		end
	end

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		clkdist_channel u_ch (
			.ref_clk  (ref_clk),
			.nrst     (nrst),
			.path_tick(path_tick),
			.align    (align),
			.gate     (gate),
			.path_sel (ch_word_reg[g][CH_MUX_LSB +: 2]),
			.div_code (ch_word_reg[g][CH_DIV_LSB +: 8]),
			.dly_code (ch_word_reg[g][CH_DLY_LSB +: 4]),
			.ch_en    (ch_word_reg[g][CH_EN_BIT]),
			.clk_out  (ch_clk[g]),
			.out_en   (ch_out_en[g]),
			.delay_ps (ch_delay_ps[g])
		);
	end
endmodule

/* clkdist_pkg.sv */
/*
 clkdist_pkg: register offsets, field positions, reset values and timing counts
 for the clock output channel configuration block.
 assumes a 250 MHz ref_clk and a 32-bit AXI4-Lite register bus.
*/
package clkdist_pkg;
	localparam int          NUM_CH          = 8;
	localparam int          REF_CLK_MHZ     = 250;
	// register byte offsets
	localparam logic [7:0]  CH_WORD_BASE    = 8'h00;
	localparam logic [7:0]  SWING_OFS       = 8'h20;
	localparam logic [7:0]  PRESCALE_OFS    = 8'h24;
	localparam logic [7:0]  LOOP_FILTER_OFS = 8'h28;
	localparam logic [7:0]  FIXED_OFS       = 8'h2C;
	localparam logic [7:0]  GLOBAL_OFS      = 8'h30;
	localparam logic [7:0]  FEEDBACK_OFS    = 8'h34;
	localparam logic [7:0]  STATUS_OFS      = 8'h38;
	// channel word fields
	localparam int          CH_MUX_LSB      = 17;
	localparam int          CH_EN_BIT       = 16;
	localparam int          CH_DIV_LSB      = 8;
	localparam int          CH_DLY_LSB      = 4;
	localparam int          OSC_SEL_LSB     = 25;
	// other fields
	localparam int          SWING_BIT       = 16;
	localparam int          PRESCALE_BIT    = 15;
	localparam int          CAP_LSB         = 4;
	localparam int          ALL_EN_BIT      = 27;
	localparam int          ZERO_DLY_BIT    = 28;
	localparam int          OSC_DIV_LSB     = 26;
	localparam int          FB_COUNT_LSB    = 8;
	// reset values
	localparam logic [7:0]  DIV_RESET       = 8'h01;
	localparam logic [3:0]  OSC_DIV_RESET   = 4'h2;
	localparam logic [17:0] FB_COUNT_RESET  = 18'h002F8;
	localparam logic        ALL_EN_RESET    = 1'b1;
	// path select codes
	localparam logic [1:0]  OSC_FROM_DIV    = 2'h0;
	localparam logic [1:0]  OSC_DIRECT      = 2'h2;
	localparam logic [1:0]  PATH_BYPASS     = 2'h0;
	localparam logic [1:0]  PATH_DIV        = 2'h1;
	localparam logic [1:0]  PATH_DLY        = 2'h2;
	localparam logic [1:0]  PATH_DIV_DLY    = 2'h3;
	// added delays in ps
	localparam logic [11:0] DIV_ADD_PS      = 12'h064;
	localparam logic [11:0] DLY_ADD_PS      = 12'h190;
	localparam logic [11:0] DIV_DLY_ADD_PS  = 12'h1F4;
	localparam logic [11:0] DLY_STEP_PS     = 12'h096;
	// calibration time and lock detect prescale count
	localparam int          CAL_TIME_US     = 2000;
	localparam int          CAL_CYCLES      = CAL_TIME_US * REF_CLK_MHZ;
	localparam logic [1:0]  PRESCALE_LAST   = 2'h3;
	// axi responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* clkdist_channel.sv */
/*
 clkdist_channel: one output channel, path select, even divider, delay value
 and enable gating.
 assumes path_tick is one pulse per path clock period on ref_clk.
*/
`timescale 1ns/1ps
module clkdist_channel
	import clkdist_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// source
	input  wire logic        path_tick,
	input  wire logic        align,
	input  wire logic        gate,
	// configuration
	input  wire logic [1:0]  path_sel,
	input  wire logic [7:0]  div_code,
	input  wire logic [3:0]  dly_code,
	input  wire logic        ch_en,
	// output
	output logic             clk_out,
	output logic             out_en,
	output logic [11:0]      delay_ps
);
	logic [7:0]  div_cnt_reg;
	logic        div_q_reg;
	logic [7:0]  eff_code;
	logic        uses_div;
	logic        uses_dly;
	logic [11:0] dly_add;

	assign eff_code = (div_code == 8'h00) ? DIV_RESET : div_code;
	assign uses_div = (path_sel == PATH_DIV) || (path_sel == PATH_DIV_DLY);
	assign uses_dly = (path_sel == PATH_DLY) || (path_sel == PATH_DIV_DLY);
	assign dly_add  = uses_dly ? dly_step(dly_code) : 12'h000;

	// divider toggles every code ticks, period twice the code
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_reg <= 8'h00;
			div_q_reg   <= 1'b0;
		end else if (align) begin
			div_cnt_reg <= 8'h00;
			div_q_reg   <= 1'b0;
		end else if (path_tick) begin
			if (div_cnt_reg >= eff_code - 8'h01) begin
				div_cnt_reg <= 8'h00;
				div_q_reg   <= ~div_q_reg;
			end else begin
				div_cnt_reg <= div_cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clk_out <= 1'b0;
			out_en  <= 1'b0;
		end else begin
			out_en  <= ch_en & gate;
			clk_out <= (ch_en & gate) & (uses_div ? div_q_reg : path_tick);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			delay_ps <= 12'h000;
		end else begin
			case (path_sel)
				PATH_BYPASS: delay_ps <= 12'h000;
				PATH_DIV:    delay_ps <= DIV_ADD_PS;
				PATH_DLY:    delay_ps <= DLY_ADD_PS + dly_add;
				PATH_DIV_DLY: delay_ps <= DIV_DLY_ADD_PS + dly_add;
				default:     delay_ps <= 12'h000;
			endcase
		end
	end

	function automatic logic [11:0] dly_step(input logic [3:0] code);
		logic [15:0] p;
		p = {12'h000, code} * {4'h0, DLY_STEP_PS};
		return p[11:0];
	endfunction
endmodule

/* clkdist_top_sva.sv */
/*
 checker for clkdist_top: bus holds, calibration timing, delay values, gating.
 assumes CAL_LEN matches the design instance and one ref_clk domain.
*/
`timescale 1ns/1ps
module clkdist_top_sva
	import clkdist_pkg::*;
#(
	parameter int CAL_LEN = 20
)(
	input wire logic                    ref_clk,
	input wire logic                    nrst,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic                    outputs_enable_pin,
	input wire logic                    pd_tick,
	input wire logic                    ld_tick,
	input wire logic                    feedback_from_selector,
	input wire logic                    calibrating,
	input wire logic                    sync_pulse,
	input wire logic [NUM_CH-1:0]       ch_out_en,
	input wire logic [NUM_CH-1:0][11:0] ch_delay_ps
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic [31:0] cal_cnt;
	// cycles of one calibration run so far
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) cal_cnt <= '0;
		else if (!calibrating) cal_cnt <= '0;
		else if (sync_pulse) cal_cnt <= 32'h1;
		else cal_cnt <= cal_cnt + 32'h1;
	end
	function automatic logic legal(input logic [11:0] d);
		return d == 0 || d == 100 || (d >= 400 && d <= 2650 && (d - 400) % 150 == 0)
			|| (d >= 500 && d <= 2750 && (d - 500) % 150 == 0);
	endfunction
	sequence pin_low_long;
		!outputs_enable_pin [*6];
	endsequence
	sequence cal_start;
		$rose(calibrating);
	endsequence
	a_delay_legal: assert property (legal(ch_delay_ps[0]) && legal(ch_delay_ps[1]))
		else $error("channel delay value outside the allowed set");
	a_pin_gates_all: assert property (pin_low_long |-> ch_out_en == '0)
		else $error("output enabled while enable pin held low");
	a_cal_bound: assert property (calibrating && !sync_pulse |-> cal_cnt < CAL_LEN)
		else $error("calibration longer than its length");
	a_cal_end: assert property ($fell(calibrating) |-> $past(cal_cnt) == CAL_LEN - 1)
		else $error("calibration ended early");
	a_cal_with_sync: assert property (cal_start |-> sync_pulse)
		else $error("calibration started without a sync pulse");
	a_zero_dly_block: assert property (sync_pulse && $past(feedback_from_selector)
		&& !$past(calibrating) |-> !calibrating)
		else $error("calibration started in zero-delay operation");
	a_sync_single: assert property (sync_pulse |=> !sync_pulse)
		else $error("sync pulse longer than one cycle");
	a_ld_from_pd: assert property (ld_tick |-> $past(pd_tick))
		else $error("lock detect tick without phase detector tick");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp) && !s_axi_awready && !s_axi_wready)
		else $error("write response dropped or changed");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data dropped or changed");
endmodule

bind clkdist_top clkdist_top_sva #(.CAL_LEN(CAL_LEN)) u_sva (.ref_clk(ref_clk), .nrst(nrst),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.outputs_enable_pin(outputs_enable_pin), .pd_tick(pd_tick), .ld_tick(ld_tick),
	.feedback_from_selector(feedback_from_selector), .calibrating(calibrating),
	.sync_pulse(sync_pulse), .ch_out_en(ch_out_en), .ch_delay_ps(ch_delay_ps));

/* host_pins.sv */
/*
 host_pins: far side pins, phase detector ticks and the alignment pulse.
 assumes align_req is a one-cycle request on ref_clk.
*/
`timescale 1ns/1ps
module host_pins (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic align_req,
	output logic      pd_tick,
	output logic      align_n_pin
);
	logic [3:0] ph;
	logic [3:0] hold;
	// one tick every five cycles
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) ph <= 4'h0;
		else ph <= (ph == 4'h4) ? 4'h0 : ph + 4'h1;
	end
	assign pd_tick = (ph == 4'h4);
	// low pulse of eight cycles after the dividers are set
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) hold <= 4'h0;
		else if (align_req) hold <= 4'h8;
		else if (hold != 4'h0) hold <= hold - 4'h1;
	end
	assign align_n_pin = (hold == 4'h0);
endmodule

/* clkdist_top_bench.sv */
/*
 clkdist_top_bench: register access, channel paths, dividers, gating, calibration.
 assumes host_pins as the pin side and CAL_LEN of 20.
*/
`timescale 1ns/1ps
module clkdist_top_bench;
	import clkdist_pkg::*;
	localparam int CAL = 20;
	logic                    ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic                    awready, wready, bvalid, arready, rvalid, oe_pin, align_req;
	logic                    pd_tick, align_n, ld_tick, swing, fb_sel, cal, sync;
	logic [7:0]              awaddr, araddr;
	logic [31:0]             wdata, rdata;
	logic [1:0]              bresp, rresp;
	logic [3:0]              wstrb, cap;
	logic [NUM_CH-1:0]       ch_clk, ch_oe;
	logic [NUM_CH-1:0][11:0] dly;
	int                      fail_count, n_compared;
	clkdist_top #(.CAL_LEN(CAL)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.outputs_enable_pin(oe_pin), .align_n_pin(align_n), .pd_tick(pd_tick),
		.ld_tick(ld_tick), .output_swing_raise(swing), .loop_filter_cap_code(cap),
		.feedback_from_selector(fb_sel), .calibrating(cal), .sync_pulse(sync),
		.ch_clk(ch_clk), .ch_out_en(ch_oe), .ch_delay_ps(dly));
	host_pins u_pins (.ref_clk(ref_clk), .nrst(nrst), .align_req(align_req),
		.pd_tick(pd_tick), .align_n_pin(align_n));
	always #2 ref_clk = ~ref_clk;
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	task automatic smp(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	function automatic logic [31:0] chw(input logic [1:0] p, input logic e,
		input logic [7:0] dv, input logic [3:0] dl);
		return {13'h0, p, e, dv, dl, 4'h0};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic tb, sa, sw, sb;
		logic [1:0] r;
		tb = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 64 && !tb; i++) begin
			@(negedge ref_clk);
			sa = awvalid && awready;
			sw = wvalid && wready;
			sb = bvalid;
			r = bresp;
			@(posedge ref_clk);
			if (sa) awvalid <= 1'b0;
			if (sw) wvalid <= 1'b0;
			if (sb) begin
				bready <= 1'b0;
				tb = 1'b1;
			end
		end
		if (!tb) begin
			fail_count++;
			summarize();
		end else begin
			check("bresp", er, r);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
		int i;
		logic tr, sa;
		logic [1:0] r;
		logic [31:0] d;
		tr = 1'b0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 64 && !tr; i++) begin
			@(negedge ref_clk);
			sa = arvalid && arready;
			tr = rvalid;
			r = rresp;
			d = rdata;
			@(posedge ref_clk);
			if (sa) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		if (!tr) begin
			fail_count++;
			summarize();
		end else begin
			check("rresp", er, r);
			check("rdata", ed, d);
		end
	endtask
	task automatic period(input int ch, input int exp);
		int i, t0, k;
		logic p;
		k = 0;
		p = 1'b1;
		for (i = 0; i < 600 && k < 2; i++) begin
			@(negedge ref_clk);
			if (ch_clk[ch] === 1'b1 && !p) begin
				k++;
				if (k == 1) t0 = i;
				else check("period", exp, i - t0);
			end
			p = ch_clk[ch];
		end
		if (k < 2) begin
			check("period_seen", 1, 0);
			summarize();
		end
	endtask
	task automatic ld_count(input int lo, input int hi);
		int i, n;
		n = 0;
		for (i = 0; i < 200; i++) begin
			@(negedge ref_clk);
			if (ld_tick === 1'b1) n++;
		end
		check("ld_ticks", 1, n >= lo && n <= hi);
	endtask
	task automatic cal_run(input logic [31:0] g, input logic [31:0] fb, input int ec);
		int i, nc, ns;
		nc = 0;
		ns = 0;
		wr(GLOBAL_OFS, g, RESP_OKAY);
		smp(1);
		check("fb_sel", g[28], fb_sel);
		fork
			wr(FEEDBACK_OFS, fb, RESP_OKAY);
			for (i = 0; i < 40; i++) begin
				@(negedge ref_clk);
				if (cal === 1'b1) nc++;
				if (sync === 1'b1) ns++;
			end
		join
		check("cal_cycles", ec, nc);
		check("sync_count", 1, ns);
	endtask
	task automatic t_regs();
		rd(CH_WORD_BASE, RESP_OKAY, 32'h00000100);
		rd(GLOBAL_OFS, RESP_OKAY, 32'h08000000);
		rd(SWING_OFS, RESP_OKAY, 32'h0);
		rd(PRESCALE_OFS, RESP_OKAY, 32'h0);
		rd(STATUS_OFS, RESP_OKAY, 32'h00000006);
		check("swing", 1'b0, swing);
		rd(8'h40, RESP_SLVERR, 32'h0);
		wr(8'h40, 32'hFFFFFFFF, RESP_SLVERR);
		wr(FIXED_OFS, 32'h00000001, RESP_OKAY);
		wr(LOOP_FILTER_OFS, 32'h000000B0, RESP_OKAY);
		wr(SWING_OFS, 32'h00010000, RESP_OKAY);
		smp(1);
		check("cap", 4'hB, cap);
		check("swing", 1'b1, swing);
		@(posedge ref_clk);
		wstrb <= 4'h2;
		wr(FIXED_OFS, 32'hFFFFFFFF, RESP_OKAY);
		wstrb <= 4'hF;
		rd(FIXED_OFS, RESP_OKAY, 32'h0000FF01);
	endtask
	task automatic t_delay();
		int ex[4] = '{0, 100, 1150, 1250};
		int p;
		for (p = 0; p < 4; p++) begin
			wr(CH_WORD_BASE, chw(p[1:0], 1'b1, 8'h01, 4'h5), RESP_OKAY);
			smp(2);
			check("delay", ex[p], dly[0]);
		end
		wr(CH_WORD_BASE, chw(PATH_DIV_DLY, 1'b1, 8'h01, 4'hF), RESP_OKAY);
		smp(2);
		check("delay_max", 2750, dly[0]);
	endtask
	task automatic t_enable();
		check("own_en", 1'b1, ch_oe[0]);
		check("off_en", 1'b0, ch_oe[2]);
		wr(GLOBAL_OFS, 32'h0, RESP_OKAY);
		smp(2);
		check("global_off", 8'h00, ch_oe);
		wr(GLOBAL_OFS, 32'h08000000, RESP_OKAY);
		oe_pin <= 1'b0;
		smp(8);
		check("pin_off", 8'h00, ch_oe);
		@(posedge ref_clk);
		oe_pin <= 1'b1;
		smp(8);
		check("pin_on", 1'b1, ch_oe[0]);
	endtask
	task automatic t_divide();
		wr(CH_WORD_BASE + 8'h04, chw(PATH_BYPASS, 1'b1, 8'h03, 4'h0), RESP_OKAY);
		period(1, 2);
		wr(CH_WORD_BASE + 8'h04, chw(PATH_DIV, 1'b1, 8'h03, 4'h0), RESP_OKAY);
		period(1, 12);
		wr(CH_WORD_BASE + 8'h1C, 32'h04000000, RESP_OKAY);
		period(1, 6);
	endtask
	task automatic t_align();
		int i;
		wr(CH_WORD_BASE, chw(PATH_DIV, 1'b1, 8'h02, 4'h0), RESP_OKAY);
		smp(3);
		wr(CH_WORD_BASE + 8'h04, chw(PATH_DIV, 1'b1, 8'h02, 4'h0), RESP_OKAY);
		@(posedge ref_clk);
		align_req <= 1'b1;
		@(posedge ref_clk);
		align_req <= 1'b0;
		smp(30);
		for (i = 0; i < 24; i++) begin
			@(negedge ref_clk);
			check("aligned", 1'b1, ch_clk[0] === ch_clk[1]);
		end
		period(0, 4);
	endtask
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, align_req} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		oe_pin = 1'b1;
		fail_count = 0;
		n_compared = 0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs();
		ld_count(39, 41);
		wr(PRESCALE_OFS, 32'h00008000, RESP_OKAY);
		ld_count(9, 11);
		t_delay();
		t_enable();
		cal_run(32'h08000000, 32'h0802F800, CAL);
		t_divide();
		cal_run(32'h18000000, 32'h0805F000, 0);
		wr(GLOBAL_OFS, 32'h08000000, RESP_OKAY);
		smp(1);
		check("fb_sel", 1'b0, fb_sel);
		t_align();
		summarize();
	end
endmodule
